// ---- uepc_pkg.sv ----
// Constants, register map and carrier types for the endpoint/pipe control block.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus.
package uepc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BUS_RESET_US = 10;
  localparam int unsigned BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ;
  localparam int unsigned NUM_PIPES = 4;
  localparam int unsigned BCNT_W = 10;
  localparam int unsigned MEM_BYTES = 1024;
  localparam int unsigned PIPE_MAX_BYTES = 256;
  localparam int unsigned PIPE_MAX_BANKS = 2;
  localparam logic [6:0] DEFAULT_ADDR = 7'h00;

  // Register byte offsets
  localparam logic [7:0] A_EP_STAT = 8'h00;
  localparam logic [7:0] A_EP_CTRL = 8'h04;
  localparam logic [7:0] A_EP_CLR = 8'h08;
  localparam logic [7:0] A_EP_FIFO = 8'h0c;
  localparam logic [7:0] A_FRAME = 8'h10;
  localparam logic [7:0] A_HOST_CTRL = 8'h14;
  localparam logic [7:0] A_HOST_STAT = 8'h18;
  localparam logic [7:0] A_HOST_CLR = 8'h1c;
  localparam logic [7:0] A_PIPE_RST = 8'h20;
  localparam logic [7:0] A_PIPE_EN = 8'h24;
  localparam logic [7:0] A_PIPE_CFG0 = 8'h40;
  localparam logic [7:0] A_PIPE_STAT0 = 8'h60;

  // Endpoint status bits
  localparam int unsigned B_RXOUT = 0;
  localparam int unsigned B_UNDER = 1;
  localparam int unsigned B_OVER = 2;
  localparam int unsigned B_CRC = 3;
  localparam int unsigned B_HAND = 4;
  localparam int unsigned B_RW_ALLOWED_FLAG = 5;
  localparam int unsigned B_BANK_BYTE_COUNT = 16;
  // Endpoint control bits
  localparam int unsigned B_ISO = 4;
  // Host control bits
  localparam int unsigned B_ENA = 0;
  localparam int unsigned B_PWR = 1;
  localparam int unsigned B_FRAME_MARKER_GEN_ENABLE = 2;
  localparam int unsigned B_BRST = 3;
  // Host status bits
  localparam int unsigned B_BUS_RESET_SENT_FLAG = 0;
  localparam int unsigned B_HWUP = 1;
  localparam int unsigned B_HST = 4;
  // Pipe config fields
  localparam int unsigned B_PSIZE = 0;
  localparam int unsigned B_PBK = 10;
  localparam int unsigned B_TOKEN = 12;
  localparam int unsigned B_INTF = 16;
  localparam int unsigned B_PADDR = 24;

  typedef enum logic [2:0] {
    HS_RESET = 3'b000,
    HS_IDLE = 3'b001,
    HS_READY = 3'b011,
    HS_SUSPEND = 3'b010,
    HS_BUSRST = 3'b110
  } uepc_host_e;

  // Packet events from the link engine
  typedef struct packed {
    logic done;
    logic iso;
    logic crc_bad;
    logic [BCNT_W-1:0] len;
  } uepc_rxpkt_s;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] intf;
    logic [1:0] token;
    logic [1:0] banks;
    logic [9:0] size;
  } uepc_pcfg_s;
endpackage : uepc_pkg

// ---- uepc_top.sv ----
// USB endpoint OUT flow, error flags and host pipe control with AHB-Lite registers.
// Assumes the link engine delivers packets and line states synchronous to hclk.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
module uepc_top import uepc_pkg::*; #(
  parameter int unsigned PIPES = NUM_PIPES,
  parameter int unsigned BANK_BYTES = 64,
  parameter int unsigned RST_CYC = BUS_RESET_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire uepc_rxpkt_s rx_pkt,
  input wire logic in_token_iso,
  input wire logic frame_marker,
  input wire logic frame_crc_bad,
  input wire logic [10:0] frame_number,
  input wire logic role_select_pin,
  input wire logic dp_line,
  input wire logic dm_line,
  output logic endpoint_irq,
  output logic send_zlp,
  output logic bus_reset_drive,
  output logic bus_power_request,
  output logic frame_marker_gen_enable,
  output logic [PIPES-1:0] pipe_active,
  output logic [PIPES-1:0] config_valid_flag
);
  localparam int unsigned NB = 2;
  localparam logic [BCNT_W-1:0] BANK_MAX = BCNT_W'(BANK_BYTES);

  // Bus address phase capture
  logic wr_pend_r;
  logic rd_fifo;
  logic [7:0] wa_r;
  logic [31:0] rdata_nxt;
  wire logic take = hsel && hready && htrans[1];
  wire logic wr_en = wr_pend_r;
  assign rd_fifo = take && !hwrite && haddr[7:0] == A_EP_FIFO;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      wa_r <= haddr[7:0];
    end
  end

  // Endpoint state
  logic [BCNT_W-1:0] bcnt_r [NB];
  logic [NB-1:0] full_r;
  logic cur_r;
  logic rxout_r, under_r, over_r, crc_r, hand_r;
  logic [3:0] ep_ie_r;
  logic iso_r;
  logic frame_number_crc_error_r;
  logic [10:0] fnum_r;
  logic [7:0] mem_r [NB][BANK_BYTES];
  logic [$clog2(BANK_BYTES)-1:0] rptr_r;
  wire logic w1_clr = wr_en && wa_r == A_EP_CLR;
  wire logic fill_bank = !cur_r ? (!full_r[0] ? 1'b0 : 1'b1) : (!full_r[1] ? 1'b1 : 1'b0);
  wire logic all_full = &full_r;
  wire logic rx_take = rx_pkt.done && !all_full;
  wire logic hand_clr = w1_clr && hwdata[B_HAND] && hand_r;
  wire logic nxt_full = full_r[~cur_r];
  wire logic cur_full_now = full_r[cur_r] && !hand_r;
  wire logic [BCNT_W-1:0] cur_cnt = bcnt_r[cur_r];
  wire logic rd_pop = rd_fifo && hand_r && cur_cnt != '0;

  always_ff @(posedge hclk) begin
    if (rx_take) begin
      mem_r[fill_bank][0] <= rx_pkt.len[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_r <= '0;
      for (int i = 0; i < NB; i++) begin
        bcnt_r[i] <= '0;
      end
    end else begin
      if (rx_take) begin
        full_r[fill_bank] <= 1'b1;
        bcnt_r[fill_bank] <= (rx_pkt.len > BANK_MAX) ? BANK_MAX : rx_pkt.len;
      end
      if (rd_pop) begin
        bcnt_r[cur_r] <= cur_cnt - BCNT_W'(1);
      end
      if (hand_clr) begin
        full_r[cur_r] <= 1'b0;
        bcnt_r[cur_r] <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_r <= 1'b0;
      rptr_r <= '0;
    end else if (hand_clr) begin
      cur_r <= ~cur_r;
      rptr_r <= '0;
    end else if (rd_pop) begin
      rptr_r <= rptr_r + 1'b1;
    end
  end

  // Received flag and handoff; a set beats a same-cycle clear
  wire logic cur_fills = rx_take && fill_bank == cur_r && !hand_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxout_r <= 1'b0;
      hand_r <= 1'b0;
    end else begin
      if (cur_fills || cur_full_now) begin
        rxout_r <= 1'b1;
        hand_r <= 1'b1;
      end else if (hand_clr) begin
        rxout_r <= nxt_full;
        hand_r <= nxt_full;
      end else if (w1_clr && hwdata[B_RXOUT]) begin
        rxout_r <= 1'b0;
      end
    end
  end

  // Error flags, sticky until written one
  wire logic ev_under = iso_r && ((in_token_iso && !full_r[cur_r]) || (rx_pkt.done && all_full));
  wire logic ev_over = rx_take && rx_pkt.len > BANK_MAX;
  wire logic ev_crc = rx_take && iso_r && rx_pkt.crc_bad;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      under_r <= 1'b0;
      over_r <= 1'b0;
      crc_r <= 1'b0;
    end else begin
      under_r <= ev_under || (under_r && !(w1_clr && hwdata[B_UNDER]));
      over_r <= ev_over || (over_r && !(w1_clr && hwdata[B_OVER]));
      crc_r <= ev_crc || (crc_r && !(w1_clr && hwdata[B_CRC]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_zlp <= 1'b0;
    end else begin
      send_zlp <= iso_r && in_token_iso && !full_r[cur_r];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_number_crc_error_r <= 1'b0;
      fnum_r <= '0;
    end else if (frame_marker) begin
      frame_number_crc_error_r <= frame_crc_bad;
      if (!frame_crc_bad) begin
        fnum_r <= frame_number;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ep_ie_r <= '0;
      iso_r <= 1'b0;
    end else if (wr_en && wa_r == A_EP_CTRL) begin
      ep_ie_r <= hwdata[3:0];
      iso_r <= hwdata[B_ISO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      endpoint_irq <= 1'b0;
    end else begin
      endpoint_irq <= |({crc_r, over_r, under_r, rxout_r} & ep_ie_r);
    end
  end

  // Host state machine
  uepc_host_e hst_r;
  logic ena_r, frame_marker_gen_enable_r, bus_reset_sent_flag_r, hwup_r;
  logic [$clog2(RST_CYC+1)-1:0] rcnt_r;
  wire logic host_on = ena_r && !role_select_pin;
  wire logic connected = dp_line || dm_line;
  wire logic detached = !dp_line && !dm_line;
  wire logic hc_wr = wr_en && wa_r == A_HOST_CTRL;
  wire logic brst_req = hc_wr && hwdata[B_BRST];
  wire logic brst_done = hst_r == HS_BUSRST && rcnt_r == '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst_r <= HS_RESET;
      rcnt_r <= '0;
    end else if (!host_on) begin
      hst_r <= HS_RESET;
    end else begin
      unique case (hst_r)
        HS_RESET: hst_r <= HS_IDLE;
        HS_IDLE: if (bus_power_request && connected) hst_r <= HS_READY;
        HS_READY: begin
          if (detached) hst_r <= HS_IDLE;
          else if (brst_req) begin
            hst_r <= HS_BUSRST;
            rcnt_r <= ($bits(rcnt_r))'(RST_CYC - 1);
          end else if (!frame_marker_gen_enable_r) hst_r <= HS_SUSPEND;
        end
        HS_SUSPEND: begin
          if (detached) hst_r <= HS_IDLE;
          else if (brst_req) begin
            hst_r <= HS_BUSRST;
            rcnt_r <= ($bits(rcnt_r))'(RST_CYC - 1);
          end else if (frame_marker_gen_enable_r) hst_r <= HS_READY;
        end
        HS_BUSRST: begin
          if (rcnt_r == '0) hst_r <= HS_READY;
          else rcnt_r <= rcnt_r - 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reset_drive <= 1'b0;
    end else begin
      bus_reset_drive <= host_on && hst_r == HS_BUSRST && rcnt_r != '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ena_r <= 1'b0;
      frame_marker_gen_enable_r <= 1'b0;
      bus_power_request <= 1'b0;
    end else begin
      if (hc_wr) begin
        ena_r <= hwdata[B_ENA];
        frame_marker_gen_enable_r <= hwdata[B_FRAME_MARKER_GEN_ENABLE];
        if (hwdata[B_PWR]) bus_power_request <= 1'b1;
      end
      if (brst_done && !frame_marker_gen_enable_r) frame_marker_gen_enable_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_marker_gen_enable <= 1'b0;
    end else begin
      frame_marker_gen_enable <= frame_marker_gen_enable_r && hst_r == HS_READY;
    end
  end

  wire logic hs_clr = wr_en && wa_r == A_HOST_CLR;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reset_sent_flag_r <= 1'b0;
      hwup_r <= 1'b0;
    end else begin
      bus_reset_sent_flag_r <= brst_done || (bus_reset_sent_flag_r && !(hs_clr && hwdata[B_BUS_RESET_SENT_FLAG]));
      hwup_r <= (brst_done && !frame_marker_gen_enable_r) || (hwup_r && !(hs_clr && hwdata[B_HWUP]));
    end
  end

  // Pipes
  logic [PIPES-1:0] prst_r, pen_r, tog_r, busy_r;
  uepc_pcfg_s pcfg_r [PIPES];
  genvar g;
  generate
    for (g = 0; g < PIPES; g++) begin : g_pipe
      wire logic cfg_wr = wr_en && wa_r == A_PIPE_CFG0 + 8'(4 * g);
      wire logic ok = pcfg_r[g].size != '0 && pcfg_r[g].size <= 10'(PIPE_MAX_BYTES)
        && pcfg_r[g].banks != '0 && pcfg_r[g].banks <= 2'(PIPE_MAX_BANKS)
        && 32'(pcfg_r[g].size) * 32'(pcfg_r[g].banks) <= 32'(MEM_BYTES);
      wire logic held = prst_r[g] || !pen_r[g];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pcfg_r[g] <= '0;
        end else begin
          if (cfg_wr) begin
            if (config_valid_flag[g]) begin
              pcfg_r[g].token <= hwdata[B_TOKEN +: 2];
              pcfg_r[g].intf <= hwdata[B_INTF +: 8];
            end else begin
              pcfg_r[g] <= {hwdata[B_PADDR +: 7], hwdata[B_INTF +: 8], hwdata[B_TOKEN +: 2],
                hwdata[B_PBK +: 2], hwdata[B_PSIZE +: 10]};
            end
            pcfg_r[g].addr <= hwdata[B_PADDR +: 7];
          end
          if (brst_done) pcfg_r[g].addr <= DEFAULT_ADDR;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tog_r[g] <= 1'b0;
          busy_r[g] <= 1'b0;
          config_valid_flag[g] <= 1'b0;
          pipe_active[g] <= 1'b0;
        end else begin
          if (!pen_r[g]) tog_r[g] <= 1'b0;
          busy_r[g] <= held ? 1'b0 : busy_r[g];
          config_valid_flag[g] <= pen_r[g] && ok;
          pipe_active[g] <= !held && pen_r[g] && ok;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prst_r <= '0;
      pen_r <= '0;
    end else begin
      if (wr_en && wa_r == A_PIPE_RST) prst_r <= hwdata[PIPES-1:0];
      if (wr_en && wa_r == A_PIPE_EN) pen_r <= hwdata[PIPES-1:0];
      if (brst_done) pen_r <= '0;
    end
  end

  // Read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (haddr[7:0])
      A_EP_STAT: begin
        rdata_nxt[B_RXOUT] = rxout_r;
        rdata_nxt[B_UNDER] = under_r;
        rdata_nxt[B_OVER] = over_r;
        rdata_nxt[B_CRC] = crc_r;
        rdata_nxt[B_HAND] = hand_r;
        rdata_nxt[B_RW_ALLOWED_FLAG] = hand_r && cur_cnt != '0;
        rdata_nxt[B_BANK_BYTE_COUNT +: BCNT_W] = cur_cnt;
      end
      A_EP_CTRL: rdata_nxt[B_ISO:0] = {iso_r, ep_ie_r};
      A_EP_FIFO: rdata_nxt[7:0] = mem_r[cur_r][rptr_r];
      A_FRAME: rdata_nxt[11:0] = {frame_number_crc_error_r, fnum_r};
      A_HOST_CTRL: rdata_nxt[B_FRAME_MARKER_GEN_ENABLE:0] = {frame_marker_gen_enable_r, bus_power_request, ena_r};
      A_HOST_STAT: rdata_nxt[B_HST +: 3] = hst_r;
      A_PIPE_RST: rdata_nxt[PIPES-1:0] = prst_r;
      A_PIPE_EN: rdata_nxt[PIPES-1:0] = pen_r;
      default: begin
        for (int i = 0; i < PIPES; i++) begin
          if (haddr[7:0] == A_PIPE_CFG0 + 8'(4 * i)) rdata_nxt = {1'b0, pcfg_r[i].addr, pcfg_r[i].intf,
            2'b00, pcfg_r[i].token, pcfg_r[i].banks, pcfg_r[i].size};
          if (haddr[7:0] == A_PIPE_STAT0 + 8'(4 * i)) rdata_nxt[2:0] = {tog_r[i], busy_r[i],
            config_valid_flag[i]};
        end
      end
    endcase
    if (haddr[7:0] == A_HOST_STAT) begin
      rdata_nxt[B_BUS_RESET_SENT_FLAG] = bus_reset_sent_flag_r;
      rdata_nxt[B_HWUP] = hwup_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (take && !hwrite) hrdata <= rdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : uepc_top

// ---- uepc_chk_asserts.sv ----
// Port-level checker for the endpoint/pipe control block.
// Assumes it is bound onto uepc_top and sees one clock domain.
module uepc_chk import uepc_pkg::*; #(
  parameter int unsigned PIPES = NUM_PIPES,
  parameter int unsigned RST_CYC = BUS_RESET_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic in_token_iso,
  input wire logic endpoint_irq,
  input wire logic send_zlp,
  input wire logic bus_reset_drive,
  input wire logic bus_power_request,
  input wire logic frame_marker_gen_enable,
  input wire logic [PIPES-1:0] pipe_active
);
  logic [15:0] brst_cnt_r;
  // Length of the bus reset drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brst_cnt_r <= '0;
    end else if (bus_reset_drive) begin
      brst_cnt_r <= brst_cnt_r + 16'h1;
    end else begin
      brst_cnt_r <= '0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OKAY: assert property (hresp == 1'h0 && hreadyout == 1'h1)
    else $error("slave answer not ready or not okay");
  AST_OUT_RST: assert property ($rose(hresetn) |-> !bus_reset_drive && !endpoint_irq && pipe_active == '0)
    else $error("outputs not idle after reset");
  AST_ZLP_CAUSE: assert property ($rose(send_zlp) |-> $past(in_token_iso) || $past(in_token_iso, 2))
    else $error("zero-length packet without IN token");
  AST_ZLP_PULSE: assert property (send_zlp |=> !send_zlp)
    else $error("zero-length packet request longer than one cycle");
  AST_BRST_LEN: assert property ($fell(bus_reset_drive) |-> brst_cnt_r >= RST_CYC - 1 && brst_cnt_r <= RST_CYC + 1)
    else $error("bus reset drive of wrong length");
  AST_BRST_PIPES: assert property ($fell(bus_reset_drive) |-> ##[0:2] pipe_active == '0)
    else $error("pipes still active after bus reset");
  AST_BRST_FRAME_MARKER_GEN_ENABLE: assert property ($fell(bus_reset_drive) |-> ##[0:2] frame_marker_gen_enable)
    else $error("frame generation not enabled after bus reset");
  AST_PWR_STICKY: assert property (!$fell(bus_power_request))
    else $error("bus power request dropped");
endmodule : uepc_chk

bind uepc_top uepc_chk #(.PIPES(PIPES), .RST_CYC(RST_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .in_token_iso(in_token_iso), .endpoint_irq(endpoint_irq),
  .send_zlp(send_zlp), .bus_reset_drive(bus_reset_drive), .bus_power_request(bus_power_request),
  .frame_marker_gen_enable(frame_marker_gen_enable), .pipe_active(pipe_active));

// ---- uepc_peer.sv ----
// Far-side USB peer model: packet events, frame markers and line states.
// Assumes its tasks are called just after a rising hclk edge.
module uepc_peer import uepc_pkg::*; (
  input wire logic hclk,
  output uepc_rxpkt_s rx_pkt,
  output logic in_token_iso,
  output logic frame_marker,
  output logic frame_crc_bad,
  output logic [10:0] frame_number,
  output logic dp_line,
  output logic dm_line
);
  initial begin
    rx_pkt = '0;
    in_token_iso = 1'h0;
    frame_marker = 1'h0;
    frame_crc_bad = 1'h0;
    frame_number = '0;
    dp_line = 1'h0;
    dm_line = 1'h0;
  end
  task automatic send_out(input logic [BCNT_W-1:0] len, input logic iso, input logic bad);
    rx_pkt <= {1'h1, iso, bad, len};
    @(posedge hclk);
    // Qualifiers no longer valid
    rx_pkt <= {1'h0, ~iso, ~bad, ~len};
    @(posedge hclk);
  endtask : send_out
  task automatic in_tok();
    in_token_iso <= 1'h1;
    @(posedge hclk);
    in_token_iso <= 1'h0;
  endtask : in_tok
  task automatic sof(input logic [10:0] num, input logic bad);
    frame_marker <= 1'h1;
    frame_crc_bad <= bad;
    frame_number <= num;
    @(posedge hclk);
    frame_marker <= 1'h0;
    frame_crc_bad <= ~bad;
    frame_number <= ~num;
    @(posedge hclk);
  endtask : sof
  task automatic attach();
    dp_line <= 1'h1;
    repeat (2) @(posedge hclk);
  endtask : attach
  task automatic detach();
    dp_line <= 1'h0;
    repeat (2) @(posedge hclk);
  endtask : detach
endmodule : uepc_peer

// ---- tb_usb_endpoint_pipe_control.sv ----
// Self-checking bench: AHB-Lite master, peer model and port checks.
// Assumes uepc_pkg, uepc_top, uepc_peer and the bound checker are compiled.
module tb_usb_endpoint_pipe_control import uepc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RC = 20;
  typedef struct packed {logic [9:0] len; logic iso; logic bad; logic [31:0] st;} uepc_row_s;
  uepc_row_s rows [6] = '{'{10'h00a, 1'h0, 1'h0, 32'h000a0031}, '{10'h040, 1'h0, 1'h0, 32'h00400031},
    '{10'h041, 1'h0, 1'h0, 32'h00400035}, '{10'h0c8, 1'h1, 1'h0, 32'h00400035},
    '{10'h014, 1'h1, 1'h1, 32'h00140039}, '{10'h000, 1'h0, 1'h0, 32'h00000011}};
  logic [31:0] pcfg [4] = '{32'h2a000440, 32'h0000052c, 32'h00000900, 32'h00000c08};
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic role_select_pin = 1'h1;
  logic [31:0] hrdata;
  logic hreadyout, hresp, endpoint_irq, send_zlp, bus_reset_drive, bus_power_request, frame_marker_gen_enable;
  logic in_token_iso, frame_marker, frame_crc_bad, dp_line, dm_line;
  logic [10:0] frame_number;
  logic [3:0] pipe_active, config_valid_flag;
  logic [5:0] mon;
  uepc_rxpkt_s rx_pkt;
  int miscompares = 0;
  int n_compared = 0;
  always #5 hclk = ~hclk;
  assign mon = {bus_reset_drive, pipe_active[0], bus_power_request, endpoint_irq, frame_marker_gen_enable, send_zlp};
  uepc_top #(.PIPES(4), .BANK_BYTES(64), .RST_CYC(RC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pkt(rx_pkt), .in_token_iso(in_token_iso),
    .frame_marker(frame_marker), .frame_crc_bad(frame_crc_bad), .frame_number(frame_number),
    .role_select_pin(role_select_pin), .dp_line(dp_line), .dm_line(dm_line), .endpoint_irq(endpoint_irq),
    .send_zlp(send_zlp), .bus_reset_drive(bus_reset_drive), .bus_power_request(bus_power_request),
    .frame_marker_gen_enable(frame_marker_gen_enable), .pipe_active(pipe_active),
    .config_valid_flag(config_valid_flag));
  uepc_peer peer (.hclk(hclk), .rx_pkt(rx_pkt), .in_token_iso(in_token_iso), .frame_marker(frame_marker),
    .frame_crc_bad(frame_crc_bad), .frame_number(frame_number), .dp_line(dp_line), .dm_line(dm_line));
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    chk(x & m, exp);
  endtask : rdc
  // Waits a bounded time for one monitored output to reach a level
  task automatic await(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[b] !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, mon[b]}, {31'h0, v});
  endtask : await
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk({26'h0, mon}, 32'h0);
    rdc(A_EP_STAT, '1, 32'h0);
    rdc(A_HOST_STAT, '1, 32'h0);
    wr(8'h80, '1);
    rdc(8'h80, '1, 32'h0);
    foreach (rows[i]) begin
      wr(A_EP_CTRL, {27'h0, rows[i].iso, 4'h0});
      peer.send_out(rows[i].len, rows[i].iso, rows[i].bad);
      rdc(A_EP_STAT, '1, rows[i].st);
      wr(A_EP_CLR, 32'hf);
      wr(A_EP_CLR, 32'h10);
      rdc(A_EP_STAT, '1, 32'h0);
    end
    peer.send_out(10'h3, 1'h0, 1'h0);
    wr(A_EP_CLR, 32'h1);
    rdc(A_EP_STAT, '1, 32'h00030030);
    for (int i = 2; i >= 0; i--) begin
      rdc(A_EP_FIFO, i == 2 ? 32'hff : 32'hffffff00, i == 2 ? 32'h3 : 32'h0);
      rdc(A_EP_STAT, '1, {6'h0, 10'(i), 16'h10} | (i > 0 ? 32'h20 : 32'h0));
    end
    wr(A_EP_CLR, 32'h10);
    wr(A_EP_CTRL, 32'h10);
    peer.send_out(10'h5, 1'h1, 1'h0);
    peer.send_out(10'h7, 1'h1, 1'h0);
    peer.send_out(10'h9, 1'h1, 1'h0);
    rdc(A_EP_STAT, '1, 32'h00050033);
    wr(A_EP_CLR, 32'hf);
    wr(A_EP_CLR, 32'h10);
    rdc(A_EP_STAT, '1, 32'h00070031);
    wr(A_EP_CLR, 32'h1);
    wr(A_EP_CLR, 32'h10);
    wr(A_EP_CTRL, 32'h12);
    peer.in_tok();
    await(0, 1'h1, 8);
    rdc(A_EP_STAT, '1, 32'h2);
    await(2, 1'h1, 8);
    wr(A_EP_CLR, 32'h2);
    await(2, 1'h0, 8);
    wr(A_EP_CTRL, 32'h1);
    peer.send_out(10'h4, 1'h0, 1'h0);
    await(2, 1'h1, 8);
    wr(A_EP_CLR, 32'h1);
    await(2, 1'h0, 8);
    wr(A_EP_CLR, 32'h10);
    peer.sof(11'h123, 1'h0);
    rdc(A_FRAME, 32'hfff, 32'h123);
    peer.sof(11'h124, 1'h1);
    rdc(A_FRAME, 32'h800, 32'h800);
    wr(A_HOST_CTRL, 32'h1);
    rdc(A_HOST_STAT, 32'h70, 32'h0);
    role_select_pin <= 1'h0;
    @(posedge hclk);
    rdc(A_HOST_STAT, 32'h70, 32'h10);
    wr(A_HOST_CTRL, 32'h7);
    await(3, 1'h1, 8);
    peer.attach();
    rdc(A_HOST_STAT, 32'h70, 32'h30);
    wr(A_HOST_CTRL, 32'h1);
    @(posedge hclk);
    rdc(A_HOST_STAT, 32'h70, 32'h20);
    wr(A_HOST_CTRL, 32'h5);
    @(posedge hclk);
    rdc(A_HOST_STAT, 32'h70, 32'h30);
    wr(A_HOST_CTRL, 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(A_PIPE_CFG0 + 8'(4 * p), pcfg[p]);
    end
    wr(A_PIPE_EN, 32'hf);
    repeat (2) @(posedge hclk);
    chk({28'h0, config_valid_flag}, 32'h5);
    await(4, 1'h1, 8);
    wr(A_PIPE_EN, 32'he);
    await(4, 1'h0, 8);
    wr(A_PIPE_EN, 32'hf);
    wr(A_PIPE_RST, 32'h1);
    await(4, 1'h0, 4);
    rdc(A_PIPE_CFG0, '1, pcfg[0]);
    wr(A_PIPE_RST, 32'h0);
    await(4, 1'h1, 4);
    wr(A_HOST_CTRL, 32'h9);
    await(5, 1'h1, 8);
    await(5, 1'h0, RC + 20);
    await(4, 1'h0, 4);
    await(1, 1'h1, 4);
    rdc(A_HOST_STAT, 32'h3, 32'h3);
    rdc(A_PIPE_CFG0, 32'h7f000000, 32'h0);
    wr(A_HOST_CLR, 32'h3);
    rdc(A_HOST_STAT, 32'h3, 32'h0);
    peer.detach();
    rdc(A_HOST_STAT, 32'h70, 32'h10);
    // Mid-run reset must clear the sticky power request too
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk({26'h0, mon}, 32'h0);
    rdc(A_HOST_STAT, '1, 32'h0);
    stop_test();
  end
endmodule : tb_usb_endpoint_pipe_control
